// ===== bba_core.sv
// byte and bit execution datapath with its APB register slave
// assumes a combinational file register read on fr_addr and a sequencer on skip_next
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bba_core
  import bba_pkg::*;
#(
  parameter int AW = 12 // APB address width
)
(
  input  wire logic          pclk,         // core clock, one period per cycle
  input  wire logic          presetn,      // asynchronous reset, active low
  input  wire logic          psel,         // APB select
  input  wire logic          penable,      // APB access phase
  input  wire logic          pwrite,       // APB direction
  input  wire logic [AW-1:0] paddr,        // APB byte address
  input  wire logic [31:0]   pwdata,       // APB write data
  output logic      [31:0]   prdata,       // APB read data
  output logic               pready,       // APB ready
  output logic               pslverr,      // APB error
  output logic      [6:0]    fr_addr,      // file register address
  input  wire logic [7:0]    fr_rdata,     // file register contents
  input  wire logic [7:0]    fr_pin_level, // pin levels of a port register
  input  wire logic          fr_is_port,   // addressed register is a port
  output logic      [7:0]    fr_wdata,     // file register write data
  output logic               fr_we,        // file register write strobe
  output logic               skip_next,    // discard the following instruction
  output logic               period_done   // instruction finished
);

  // elaboration check: the three offsets need at least four address bits
  if (AW < 4 || AW > 32)
  begin : g_bad_aw
    $error("bba_core: AW must be 4..32");
  end

  bba_state_t       state_q, state_d;
  logic [OPC_W-1:0] instr_q, instr_d;
  logic [7:0]       acc_q, acc_d;
  logic             flag_c_q, flag_c_d;
  logic             flag_nib_q, flag_nib_d;
  logic             flag_z_q, flag_z_d;
  logic             skip_seen_q, skip_seen_d;
  logic [6:0]       fr_addr_q, fr_addr_d;
  logic [7:0]       fr_wdata_q, fr_wdata_d;
  logic             fr_we_q, fr_we_d;
  logic             skip_q, skip_d;
  logic             done_q, done_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;

  bba_op_t    op;
  logic [7:0] alu_res, opnd;
  logic       c_out, nib_out, z_out, bit_val;
  logic       dest_file, wr_file, wr_acc, skip_take;
  logic       setup, access, busy;
  logic [11:0] addr12;

  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_q;
  assign busy   = (state_q != ST_IDLE);
  assign addr12 = 12'(paddr);
  // decoded here rather than read back from the unit, so no loop runs through it
  assign op     = bba_decode(instr_q);

  // destination and operand steering around the shared unit
  always_comb
  begin
    dest_file = instr_q[DEST_BIT];
    wr_file   = ((op == OP_ADD_REG || op == OP_AND_REG) && dest_file)
                || op == OP_CLR || op == OP_SET;
    wr_acc    = op == OP_ADD_LIT || op == OP_AND_LIT
                || ((op == OP_ADD_REG || op == OP_AND_REG) && !dest_file);
    // a port read back into itself must see the pins, not the latch
    opnd      = (fr_is_port && wr_file) ? fr_pin_level : fr_rdata;
  end

  // skip decision kept apart from the steering, whose operand feeds the tested bit
  assign skip_take = (op == OP_SKIP_HI && bit_val)
                     || (op == OP_SKIP_LO && !bit_val);

  bba_alu u_alu (
    .instr   (instr_q),
    .acc     (acc_q),
    .operand (opnd),
    .op      (),
    .res     (alu_res),
    .c_out   (c_out),
    .nib_out (nib_out),
    .z_out   (z_out),
    .bit_val (bit_val)
  );

  // APB answer: decided in the setup cycle, so pready is a flop with no wait
  always_comb
  begin
    pready_d  = setup;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (setup)
    begin
      prdata_d = 32'h0000_0000;
      case (addr12)
        ADDR_INSTR:
        begin
          prdata_d = 32'(instr_q);
          // refuse an issue while busy or an opcode this unit cannot run
          pslverr_d = pwrite && (busy || bba_decode(pwdata[OPC_W-1:0]) == OP_NONE);
        end
        ADDR_ACC:
        begin
          prdata_d  = 32'(acc_q);
          pslverr_d = pwrite && busy;
        end
        ADDR_STATUS:
        begin
          prdata_d[STAT_C_BIT]    = flag_c_q;
          prdata_d[STAT_NIB_BIT]  = flag_nib_q;
          prdata_d[STAT_Z_BIT]    = flag_z_q;
          prdata_d[STAT_BUSY_BIT] = busy;
          prdata_d[STAT_SKIP_BIT] = skip_seen_q;
          pslverr_d = pwrite && busy;
        end
        default: pslverr_d = 1'b1; // unmapped
      endcase
    end
    else if (access)
    begin
      pslverr_d = pslverr_q; // hold through the access edge
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // execution sequence: issue, one period, and a no-operation period on a skip
  always_comb
  begin
    state_d     = state_q;
    instr_d     = instr_q;
    acc_d       = acc_q;
    flag_c_d    = flag_c_q;
    flag_nib_d  = flag_nib_q;
    flag_z_d    = flag_z_q;
    skip_seen_d = skip_seen_q;
    fr_addr_d   = fr_addr_q;
    fr_wdata_d  = fr_wdata_q;
    fr_we_d     = 1'b0;
    skip_d      = 1'b0;
    done_d      = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (access && pwrite && !pslverr_q)
        begin
          case (addr12)
            ADDR_INSTR:
            begin
              instr_d     = pwdata[OPC_W-1:0];
              fr_addr_d   = pwdata[6:0];
              skip_seen_d = 1'b0;
              state_d     = ST_EXEC;
            end
            ADDR_ACC: acc_d = pwdata[7:0];
            ADDR_STATUS:
            begin
              flag_c_d   = pwdata[STAT_C_BIT];
              flag_nib_d = pwdata[STAT_NIB_BIT];
              flag_z_d   = pwdata[STAT_Z_BIT];
            end
            default: acc_d = acc_q;
          endcase
        end
      end
      ST_EXEC:
      begin
        if (wr_acc)
          acc_d = alu_res;
        if (wr_file)
        begin
          fr_we_d    = 1'b1;
          fr_wdata_d = alu_res;
        end
        if (op == OP_ADD_LIT || op == OP_ADD_REG)
        begin
          flag_c_d   = c_out;
          flag_nib_d = nib_out;
          flag_z_d   = z_out;
        end
        if (op == OP_AND_LIT || op == OP_AND_REG)
          flag_z_d = z_out;
        if (skip_take)
        begin
          skip_d      = 1'b1;
          skip_seen_d = 1'b1;
          state_d     = ST_NOP;
        end
        else
        begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_NOP:
      begin
        done_d  = 1'b1; // second period ends the skip
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= ST_IDLE;
      instr_q     <= INSTR_RST;
      acc_q       <= ACC_RST;
      flag_c_q    <= 1'b0;
      flag_nib_q  <= 1'b0;
      flag_z_q    <= 1'b0;
      skip_seen_q <= 1'b0;
      fr_addr_q   <= 7'h00;
      fr_wdata_q  <= 8'h00;
      fr_we_q     <= 1'b0;
      skip_q      <= 1'b0;
      done_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      instr_q     <= instr_d;
      acc_q       <= acc_d;
      flag_c_q    <= flag_c_d;
      flag_nib_q  <= flag_nib_d;
      flag_z_q    <= flag_z_d;
      skip_seen_q <= skip_seen_d;
      fr_addr_q   <= fr_addr_d;
      fr_wdata_q  <= fr_wdata_d;
      fr_we_q     <= fr_we_d;
      skip_q      <= skip_d;
      done_q      <= done_d;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign fr_addr     = fr_addr_q;
  assign fr_wdata    = fr_wdata_q;
  assign fr_we       = fr_we_q;
  assign skip_next   = skip_q;
  assign period_done = done_q;

  // checks, tied to the exec cycle where the work is done
  logic ex;
  assign ex = (state_q == ST_EXEC);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  add_sum_a: assert property ((ex && (op == OP_ADD_LIT || op == OP_ADD_REG) && wr_acc)
    |=> acc_q == 8'($past(acc_q) + (($past(op) == OP_ADD_LIT) ? $past(instr_q[7:0])
                                                              : $past(opnd))))
    else $error("add result wrong in accumulator");
  add_flags_a: assert property ((ex && op == OP_ADD_REG)
    |=> flag_c_q == (9'({1'b0, $past(acc_q)}) + 9'({1'b0, $past(opnd)}) > 9'h0FF)
        && flag_nib_q == (5'({1'b0, $past(acc_q[3:0])}) + 5'({1'b0, $past(opnd[3:0])}) > 5'h0F)
        && flag_z_q == (8'($past(acc_q) + $past(opnd)) == 8'h00))
    else $error("add flags wrong");
  and_flags_a: assert property ((ex && (op == OP_AND_LIT || op == OP_AND_REG))
    |=> $stable(flag_c_q) && $stable(flag_nib_q)
        && flag_z_q == (($past(acc_q) & (($past(op) == OP_AND_LIT) ? $past(instr_q[7:0])
                                                                   : $past(opnd))) == 8'h00))
    else $error("and touched carry flags or wrong zero");
  dest_file_a: assert property ((ex && (op == OP_ADD_REG || op == OP_AND_REG)
    && instr_q[DEST_BIT]) |=> fr_we && $stable(acc_q))
    else $error("file destination not honoured");
  bit_clear_a: assert property ((ex && op == OP_CLR)
    |=> fr_we && fr_wdata == ($past(opnd) & ~(8'h01 << $past(instr_q[9:7])))
        && $stable(flag_z_q) && $stable(flag_c_q))
    else $error("bit clear wrong");
  bit_set_a: assert property ((ex && op == OP_SET)
    |=> fr_we && fr_wdata == ($past(opnd) | (8'h01 << $past(instr_q[9:7])))
        && $stable(flag_z_q))
    else $error("bit set wrong");
  skip_two_a: assert property ((ex && skip_take)
    |=> skip_next && !period_done ##1 period_done && !skip_next)
    else $error("taken skip not two periods");
  skip_low_a: assert property ((ex && instr_q[13:10] == 4'h6 && !fr_rdata[instr_q[9:7]])
    |=> skip_next)
    else $error("skip when low missed");
  one_period_a: assert property ((ex && !skip_take)
    |=> period_done && !skip_next && state_q == ST_IDLE)
    else $error("single period operation overran");
  pin_source_a: assert property ((ex && fr_is_port && op == OP_SET)
    |=> fr_wdata == ($past(fr_pin_level) | (8'h01 << $past(instr_q[9:7]))))
    else $error("port operand not from pins");

  skip_seen_c: cover property (ex && skip_take);
  file_write_c: cover property (ex && wr_file && fr_is_port);
  add_carry_c: cover property (ex && op == OP_ADD_LIT && c_out && nib_out);
  refused_c: cover property (access && pslverr_q);

endmodule : bba_core
`default_nettype wire

// ===== bba_pkg.sv
// constants, types and opcode decode for the byte and bit execution datapath
// assumes a 14-bit instruction word and an 8-bit accumulator behind an APB slave
// Operation
// - add literal: accumulator plus 8-bit literal into accumulator, flags C, nibble, zero
// - add register: accumulator plus file register to destination, flags C, nibble, zero
// - destination bit 0 writes accumulator, 1 writes file register back
// - and literal: accumulator AND literal into accumulator, only zero flag changes
// - and register: accumulator AND register to destination, only zero flag changes
// - bit clear: selected register bit forced to 0, others kept, no flags
// - bit set: selected register bit forced to 1, others kept, no flags
// - skip when bit high: bit 1 discards next instruction, two periods
// - skip when bit low: bit 0 discards next instruction, two periods
// - skip when bit high decodes as 01 11 bbb fffffff
// - skip when bit low decodes as 01 10 bbb fffffff
// - port register as source and destination takes operand from pin levels
package bba_pkg;

  // register map, byte addresses of 32-bit words
  localparam logic [11:0] ADDR_INSTR  = 12'h000;
  localparam logic [11:0] ADDR_ACC    = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // status register field positions
  localparam int STAT_C_BIT    = 0;
  localparam int STAT_NIB_BIT  = 1;
  localparam int STAT_Z_BIT    = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_SKIP_BIT = 4;

  // reset values
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [13:0] INSTR_RST = 14'h0000;

  // instruction word layout
  localparam int OPC_W    = 14;
  localparam int DEST_BIT = 7;
  localparam int BIDX_LSB = 7;

  // opcode groups and sub-codes
  localparam logic [1:0] GRP_BYTE   = 2'h0;
  localparam logic [1:0] GRP_BIT    = 2'h1;
  localparam logic [1:0] GRP_LIT    = 2'h3;
  localparam logic [3:0] SUB_ADDREG = 4'h7;
  localparam logic [3:0] SUB_ANDREG = 4'h5;
  localparam logic [3:0] SUB_ANDLIT = 4'h9;
  localparam logic [2:0] SUB_ADDLIT = 3'h7;
  localparam logic [1:0] BOP_CLR    = 2'h0;
  localparam logic [1:0] BOP_SET    = 2'h1;
  localparam logic [1:0] BOP_SKIPLO = 2'h2;
  localparam logic [1:0] BOP_SKIPHI = 2'h3;

  // instruction periods of a taken skip
  localparam int SKIP_PERIODS = 2;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD_LIT, OP_ADD_REG, OP_AND_LIT, OP_AND_REG,
    OP_CLR, OP_SET, OP_SKIP_HI, OP_SKIP_LO
  } bba_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} bba_state_t;

  // decode of one instruction word
  function automatic bba_op_t bba_decode(input logic [OPC_W-1:0] w);
    bba_op_t o;
    o = OP_NONE;
    case (w[13:12])
      GRP_LIT:
      begin
        if (w[11:9] == SUB_ADDLIT) o = OP_ADD_LIT;
        else if (w[11:8] == SUB_ANDLIT) o = OP_AND_LIT;
      end
      GRP_BYTE:
      begin
        if (w[11:8] == SUB_ADDREG) o = OP_ADD_REG;
        else if (w[11:8] == SUB_ANDREG) o = OP_AND_REG;
      end
      GRP_BIT:
      begin
        case (w[11:10])
          BOP_CLR:    o = OP_CLR;
          BOP_SET:    o = OP_SET;
          BOP_SKIPLO: o = OP_SKIP_LO;
          default:    o = OP_SKIP_HI;
        endcase
      end
      default: o = OP_NONE;
    endcase
    return o;
  endfunction : bba_decode

endpackage : bba_pkg

// ===== bba_alu.sv
// combinational arithmetic, logic and bit unit of the datapath
// assumes the caller has already chosen the operand (register or pin levels)
`timescale 1ns/1ps
`default_nettype none
module bba_alu
  import bba_pkg::*;
(
  input  wire logic [OPC_W-1:0] instr,   // instruction word
  input  wire logic [7:0]       acc,     // accumulator
  input  wire logic [7:0]       operand, // file register value
  output var bba_op_t           op,      // decoded operation
  output logic      [7:0]       res,     // result byte
  output logic                  c_out,   // carry from bit 7
  output logic                  nib_out, // carry from bit 3
  output logic                  z_out,   // result is zero
  output logic                  bit_val  // tested bit
);

  logic [7:0] opnd;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] mask;
  logic [2:0] bidx;

  // operand and adder; literal forms take the low byte of the word
  always_comb
  begin
    op   = bba_decode(instr);
    bidx = instr[BIDX_LSB +: 3];
    mask = 8'h01 << bidx;
    opnd = (op == OP_ADD_LIT || op == OP_AND_LIT) ? instr[7:0] : operand;
    sum9 = {1'b0, acc} + {1'b0, opnd};
    sum5 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
    c_out   = sum9[8];
    nib_out = sum5[4];
    bit_val = operand[bidx];
    case (op)
      OP_ADD_LIT, OP_ADD_REG: res = sum9[7:0];
      OP_AND_LIT, OP_AND_REG: res = acc & opnd;
      OP_CLR:                 res = operand & ~mask;
      OP_SET:                 res = operand | mask;
      default:                res = operand;
    endcase
    z_out = (res == 8'h00);
  end

endmodule : bba_alu
`default_nettype wire

// ===== bba_fregs.sv
// file register space and port pins seen by the byte and bit datapath
// assumes fr_addr settles after a clock edge and fr_we is a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
module bba_fregs #(
  parameter logic [6:0] PORT_ADDR = 7'h05, // address modelled as an I/O port
  parameter logic [7:0] PIN_XOR   = 8'h3C  // pins pulled away from the latch
)
(
  input  wire logic       clk,       // core clock
  input  wire logic [6:0] addr,      // file address
  input  wire logic [7:0] wdata,     // write data
  input  wire logic       we,        // write strobe
  output logic      [7:0] rdata,     // latch contents
  output logic      [7:0] pin_level, // pin levels
  output logic            is_port    // address is the port
);
  logic [7:0] mem [128];

  // combinational read, sampled by the datapath in its exec cycle
  assign rdata   = mem[addr];
  assign is_port = (addr == PORT_ADDR);
  // pins differ from the latch; off the port show the inverse so a wrong pick shows
  assign pin_level = is_port ? (mem[addr] ^ PIN_XOR) : ~mem[addr];

  // plain always so the bench may preload cells between instructions
  always @(posedge clk)
    if (we)
      mem[addr] <= wdata;
endmodule : bba_fregs
`default_nettype wire

// ===== tb.sv
// self-checking bench for the byte and bit datapath
// assumes zero-wait APB answers and the file register model beside the core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bba_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  fr_addr;
  logic [7:0]  fr_rdata, fr_pin_level, fr_wdata;
  logic        fr_is_port, fr_we, skip_next, period_done, err, sk;
  int          mismatches, compares, ncyc, b;

  bba_core #(.AW(12)) i_bba_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fr_addr(fr_addr), .fr_rdata(fr_rdata),
    .fr_pin_level(fr_pin_level), .fr_is_port(fr_is_port), .fr_wdata(fr_wdata),
    .fr_we(fr_we), .skip_next(skip_next), .period_done(period_done));

  bba_fregs u_fregs (
    .clk(pclk), .addr(fr_addr), .wdata(fr_wdata), .we(fr_we),
    .rdata(fr_rdata), .pin_level(fr_pin_level), .is_port(fr_is_port));

  // 20 MHz core clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic end_sim;
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask : chk

  // one APB transfer; nxt keeps psel up, b2b starts at once after a kept one
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input bit nxt, input bit b2b);
    int i;
    if (!b2b)
      @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      mismatches++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    if (!nxt)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 1'b0);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 1'b0, 1'b0);
    chk(rd, exp);
  endtask : rdc

  // issue one instruction, count edges to completion and note a skip
  task automatic exec(input logic [13:0] ins, input int expc);
    int i;
    wr(ADDR_INSTR, {18'h0, ins});
    chk(err, 1'b0);
    sk = 1'b0;
    for (i = 1; i <= 10; i++)
    begin
      @(posedge pclk);
      if (skip_next === 1'b1)
        sk = 1'b1;
      if (period_done === 1'b1)
        break;
    end
    chk(i, expc);
    if (i > 10)
      end_sim();
    // let a file write land before the bench peeks into the model
    @(posedge pclk);
  endtask : exec

  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'hFFC, 32'h0, 1'b0, 1'b0);
    chk(err, 1'b1);
    // add literal: carries out of bit 7 and bit 3, then a zero sum
    wr(ADDR_ACC, 32'h88);
    exec(14'h3E88, 2);
    rdc(ADDR_ACC, 32'h10);
    rdc(ADDR_STATUS, 32'h3);
    wr(ADDR_ACC, 32'h10);
    exec(14'h3FF0, 2);
    rdc(ADDR_ACC, 32'h00);
    rdc(ADDR_STATUS, 32'h5);
    // and literal keeps both carries
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_ACC, 32'h3C);
    exec(14'h39C3, 2);
    rdc(ADDR_ACC, 32'h00);
    rdc(ADDR_STATUS, 32'h7);
    wr(ADDR_ACC, 32'h0F);
    exec(14'h3905, 2);
    rdc(ADDR_STATUS, 32'h3);
    // add register to accumulator, then back into the register
    u_fregs.mem[7'h20] = 8'h0F;
    u_fregs.mem[7'h21] = 8'hF0;
    wr(ADDR_ACC, 32'h01);
    exec(14'h0720, 2);
    rdc(ADDR_ACC, 32'h10);
    chk(u_fregs.mem[7'h20], 8'h0F);
    rdc(ADDR_STATUS, 32'h2);
    exec(14'h07A1, 2);
    chk(u_fregs.mem[7'h21], 8'h00);
    rdc(ADDR_ACC, 32'h10);
    rdc(ADDR_STATUS, 32'h5);
    // and with register, both destinations
    u_fregs.mem[7'h22] = 8'hAA;
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_ACC, 32'h0F);
    exec(14'h05A2, 2);
    chk(u_fregs.mem[7'h22], 8'h0A);
    rdc(ADDR_STATUS, 32'h3);
    wr(ADDR_ACC, 32'hF0);
    exec(14'h0522, 2);
    rdc(ADDR_ACC, 32'h00);
    rdc(ADDR_STATUS, 32'h7);
    // every bit position cleared and set, flags untouched
    for (b = 0; b < 8; b++)
    begin
      u_fregs.mem[7'h30] = 8'hFF;
      u_fregs.mem[7'h31] = 8'h00;
      exec(14'h1030 | 14'(b << 7), 2);
      chk(u_fregs.mem[7'h30], 8'hFF & ~(8'h01 << b));
      exec(14'h1431 | 14'(b << 7), 2);
      chk(u_fregs.mem[7'h31], 8'h01 << b);
    end
    rdc(ADDR_STATUS, 32'h7);
    // both skip tests on every bit of a mixed pattern
    u_fregs.mem[7'h40] = 8'hA5;
    for (b = 0; b < 8; b++)
    begin
      ncyc = ((8'hA5 >> b) & 1) ? 3 : 2;
      exec(14'h1C40 | 14'(b << 7), ncyc);
      chk(sk, ncyc == 3);
      exec(14'h1840 | 14'(b << 7), 5 - ncyc);
      chk(sk, ncyc == 2);
    end
    // a taken skip leaves its mark in status, flags untouched
    exec(14'h1FC0, 3);
    rdc(ADDR_STATUS, 32'h17);
    // port register modified from itself takes the pin levels
    u_fregs.mem[7'h05] = 8'h0F;
    exec(14'h1785, 2);
    chk(u_fregs.mem[7'h05], 8'hB3);
    // a second issue while busy is refused and runs nothing
    wr(ADDR_ACC, 32'h00);
    apb(1'b1, ADDR_INSTR, 32'h3E01, 1'b1, 1'b0);
    apb(1'b1, ADDR_INSTR, 32'h3E01, 1'b0, 1'b1);
    chk(err, 1'b1);
    rdc(ADDR_ACC, 32'h01);
    // status read in the exec cycle shows busy
    apb(1'b1, ADDR_INSTR, 32'h3E01, 1'b1, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, 1'b1);
    chk(rd, 32'h8);
    // a reset after the last run has finished returns accumulator and flags to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_ACC, 32'h00);
    rdc(ADDR_STATUS, 32'h00);
    end_sim();
  end
endmodule : tb
`default_nettype wire
